// File: acs_pkg.sv
`default_nettype none
package acs_pkg;
   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [7:0] ACS_OFF_BUFFER = 8'h00;
   localparam logic [7:0] ACS_OFF_MODE = 8'h04;
   localparam logic [7:0] ACS_OFF_CONTROL = 8'h08;
   localparam logic [7:0] ACS_OFF_BAUD = 8'h0C;
   localparam logic [7:0] ACS_OFF_STATUS = 8'h10;
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int ACS_MODE_RXEN = 2;
   localparam int ACS_MODE_WAKE = 3;
   localparam int ACS_MODE_CSRC = 4;
   localparam int ACS_MODE_TX9 = 7;
   localparam int ACS_CTRL_RX9 = 7;
   localparam int ACS_CTRL_EVEN = 6;
   localparam int ACS_CTRL_PE = 5;
   localparam int ACS_CTRL_OVERRUN_FLAG = 4;
   localparam int ACS_CTRL_PARITY_ERROR_FLAG = 3;
   localparam int ACS_CTRL_FRAMING_ERROR_FLAG = 2;
   localparam int ACS_BAUD_SEL_LSB = 4;
   localparam int ACS_STAT_TXEMPTY = 0;
   localparam int ACS_STAT_RXFULL = 1;
   localparam int ACS_STAT_TXBUSY = 2;
   // ***************************************************
   // Frame modes
   // ***************************************************
   localparam logic [1:0] ACS_MODE_OFF = 2'h0;
   localparam logic [1:0] ACS_MODE_7 = 2'h1;
   localparam logic [1:0] ACS_MODE_8 = 2'h2;
   localparam logic [1:0] ACS_MODE_9 = 2'h3;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] ACS_MODE_RST = 8'h00;
   localparam logic [5:0] ACS_BAUD_RST = 6'h00;
   localparam logic [7:0] ACS_PRE_RST = 8'h00;
   // ***************************************************
   // Tick counts
   // ***************************************************
   localparam logic [3:0] ACS_TICK_LAST = 4'hF;
   localparam logic [3:0] ACS_SAMPLE_FIRST = 4'h6;
   localparam logic [3:0] ACS_SAMPLE_MID = 4'h7;
   localparam logic [3:0] ACS_SAMPLE_LAST = 4'h8;
   localparam logic [3:0] ACS_BITS_7 = 4'h8;
   localparam logic [3:0] ACS_BITS_8 = 4'h9;
   localparam logic [3:0] ACS_RXBITS_7 = 4'h7;
   localparam logic [3:0] ACS_RXBITS_8 = 4'h8;
   typedef enum logic [1:0] {ACS_RX_IDLE, ACS_RX_START, ACS_RX_DATA, ACS_RX_STOP} acs_rx_state_t;
endpackage : acs_pkg
`default_nettype wire

// File: acs_sync3.sv
`default_nettype none
module acs_sync3 #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pin and filtered level
   input wire logic d,
   output logic q
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic q_ff;
   logic nxt_q;

   always_comb begin
      nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_ff <= RESET_VAL;
         s2_ff <= RESET_VAL;
         s3_ff <= RESET_VAL;
         q_ff <= RESET_VAL;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule : acs_sync3
`default_nettype wire

// File: acs_uart.sv
`default_nettype none
// Overview of operation
// - Mode field picks 7, 8 or 9 data bits per frame.
// - Parity bit only in 7-bit and 8-bit modes, never in 9-bit.
// - 9-bit mode carries a ninth bit used for slave wake-up.
// - Transmit and receive have separate buffers and run independently.
// - Receive holding buffer keeps one frame while the next is shifted in.
// - Start bit accepted only if two of three samples are low.
// - Pulse on transmit buffer empty and on received frame ready.
// - Overrun, parity and framing error flags set on detection.
// - Reading control register clears each error flag that the read returned as set.
// - Baud input is prescaler tap fc/4, 16, 64 or 256 by two-bit select.
// - 4-bit divider further divides the selected tap by 1 to 16 (value 0 gives 16).
// - Sixteen serial ticks form one bit period.
// - Timer 0 compare match may serve as serial tick source.
// - Bit value is majority of samples at ticks 7, 8 and 9.
// - With wake-up in 9-bit mode, receive only frames with ninth bit 1.
// - Transmit data goes out least significant bit first.
// - Stop bit majority of zero flags a framing error.
module acs_uart (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic rxd,
   output logic txd,
   // Timing sources
   input wire logic prescaler_run_bit,
   input wire logic timer_zero_match,
   // Events
   output logic transmit_irq,
   output logic receive_irq
);
   // ***************************************************
   // Declarations
   // ***************************************************
   logic [7:0] pre_ff, nxt_pre;
   logic [3:0] bdiv_ff, nxt_bdiv;
   logic [7:0] channel_mode_reg, nxt_mode;
   logic [5:0] baud_control_reg, nxt_baud;
   logic pe_ff, nxt_pe, even_ff, nxt_even;
   logic overrun_flag, nxt_overrun_flag, parity_error_flag, nxt_parity_error_flag, framing_error_flag, nxt_framing_error_flag;
   logic [31:0] prdata_ff, nxt_prdata;
   logic snap_full_ff, nxt_snap_full;
   logic [7:0] tx_buf_ff, nxt_tx_buf;
   logic tx_full_ff, nxt_tx_full;
   logic [11:0] tx_sh_ff, nxt_tx_sh;
   logic [3:0] tx_left_ff, nxt_tx_left, tx_tick_ff, nxt_tx_tick;
   logic txd_ff, nxt_txd, tx_irq_ff, nxt_tx_irq;
   acs_pkg::acs_rx_state_t rx_state_ff, nxt_rx_state;
   logic [3:0] rx_tick_ff, nxt_rx_tick, rx_idx_ff, nxt_rx_idx;
   logic [1:0] win_ff, nxt_win;
   logic [9:0] rx_sh_ff, nxt_rx_sh;
   logic [7:0] channel_buffer_reg, nxt_rx_buf;
   logic received_ninth_bit, nxt_rx9;
   logic rx_full_ff, nxt_rx_full, rx_irq_ff, nxt_rx_irq;
   logic prescale_div4_clk, prescale_div16_clk, prescale_div64_clk, prescale_div256_clk;
   logic tap, baud_pulse, serial_tick_clock;
   logic [3:0] bdiv_lim;
   logic setup, rd, wr, mapped;
   logic [1:0] mode;
   logic m7, m9, on, extra_en, tx_bit, tx_load, tx_par;
   logic [11:0] tx_body;
   logic rx_s, eval, maj, rx_done, suppress, rx_par_bit, rx_parity_error_flag;
   logic [3:0] rx_last;
   logic [7:0] rx_data;

   acs_sync3 #(.RESET_VAL(1'b1)) u_rx_sync (.clk(clk), .reset_n(reset_n), .d(rxd), .q(rx_s));

   // ***************************************************
   // Prescaler and baud generator
   // ***************************************************
   assign prescale_div4_clk = prescaler_run_bit & (pre_ff[1:0] == 2'h3);
   assign prescale_div16_clk = prescaler_run_bit & (pre_ff[3:0] == 4'hF);
   assign prescale_div64_clk = prescaler_run_bit & (pre_ff[5:0] == 6'h3F);
   assign prescale_div256_clk = prescaler_run_bit & (pre_ff == 8'hFF);
   always_comb begin
      case (baud_control_reg[5:4])
         2'h0: tap = prescale_div4_clk;
         2'h1: tap = prescale_div16_clk;
         2'h2: tap = prescale_div64_clk;
         default: tap = prescale_div256_clk;
      endcase
      bdiv_lim = (baud_control_reg[3:0] == 4'h0) ? acs_pkg::ACS_TICK_LAST : baud_control_reg[3:0] - 4'h1;
      baud_pulse = tap & (bdiv_ff == bdiv_lim);
      serial_tick_clock = channel_mode_reg[acs_pkg::ACS_MODE_CSRC] ? timer_zero_match : baud_pulse;
      nxt_pre = prescaler_run_bit ? pre_ff + 8'h01 : pre_ff;
      nxt_bdiv = bdiv_ff;
      if (tap) begin
         nxt_bdiv = baud_pulse ? 4'h0 : bdiv_ff + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pre_ff <= acs_pkg::ACS_PRE_RST;
         bdiv_ff <= 4'h0;
      end else begin
         pre_ff <= nxt_pre;
         bdiv_ff <= nxt_bdiv;
      end
   end

   // ***************************************************
   // APB registers
   // ***************************************************
   assign setup = psel & ~penable;
   assign rd = psel & penable & ~pwrite;
   assign wr = psel & penable & pwrite;
   assign mapped = (paddr == acs_pkg::ACS_OFF_BUFFER) | (paddr == acs_pkg::ACS_OFF_MODE) |
                   (paddr == acs_pkg::ACS_OFF_CONTROL) | (paddr == acs_pkg::ACS_OFF_BAUD) |
                   (paddr == acs_pkg::ACS_OFF_STATUS);
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_ff;

   always_comb begin
      nxt_prdata = prdata_ff;
      nxt_snap_full = snap_full_ff;
      if (setup) begin
         nxt_prdata = 32'h0000_0000;
         nxt_snap_full = rx_full_ff;
         case (paddr)
            acs_pkg::ACS_OFF_BUFFER: nxt_prdata[7:0] = channel_buffer_reg;
            acs_pkg::ACS_OFF_MODE: nxt_prdata[7:0] = channel_mode_reg;
            acs_pkg::ACS_OFF_CONTROL: nxt_prdata[7:0] = {received_ninth_bit, even_ff, pe_ff, overrun_flag,
                                                          parity_error_flag, framing_error_flag, 2'h0};
            acs_pkg::ACS_OFF_BAUD: nxt_prdata[5:0] = baud_control_reg;
            acs_pkg::ACS_OFF_STATUS: nxt_prdata[2:0] = {tx_left_ff != 4'h0, rx_full_ff, ~tx_full_ff};
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
      nxt_mode = channel_mode_reg;
      nxt_baud = baud_control_reg;
      nxt_pe = pe_ff;
      nxt_even = even_ff;
      if (wr && paddr == acs_pkg::ACS_OFF_MODE) begin
         nxt_mode = pwdata[7:0];
      end
      if (wr && paddr == acs_pkg::ACS_OFF_BAUD) begin
         nxt_baud = pwdata[5:0];
      end
      if (wr && paddr == acs_pkg::ACS_OFF_CONTROL) begin
         nxt_pe = pwdata[acs_pkg::ACS_CTRL_PE];
         nxt_even = pwdata[acs_pkg::ACS_CTRL_EVEN];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prdata_ff <= 32'h0000_0000;
         snap_full_ff <= 1'b0;
         channel_mode_reg <= acs_pkg::ACS_MODE_RST;
         baud_control_reg <= acs_pkg::ACS_BAUD_RST;
         pe_ff <= 1'b0;
         even_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         snap_full_ff <= nxt_snap_full;
         channel_mode_reg <= nxt_mode;
         baud_control_reg <= nxt_baud;
         pe_ff <= nxt_pe;
         even_ff <= nxt_even;
      end
   end

   // ***************************************************
   // Transmitter
   // ***************************************************
   assign mode = channel_mode_reg[1:0];
   assign m7 = (mode == acs_pkg::ACS_MODE_7);
   assign m9 = (mode == acs_pkg::ACS_MODE_9);
   assign on = (mode != acs_pkg::ACS_MODE_OFF);
   assign extra_en = m9 | pe_ff;
   assign tx_bit = serial_tick_clock & (tx_tick_ff == acs_pkg::ACS_TICK_LAST);
   assign tx_load = tx_bit & (tx_left_ff == 4'h0) & tx_full_ff & on;
   assign txd = txd_ff;
   assign transmit_irq = tx_irq_ff;

   always_comb begin
      tx_par = (m7 ? ^tx_buf_ff[6:0] : ^tx_buf_ff) ^ ~even_ff;
      tx_body = 12'hFFF;
      tx_body[7:0] = tx_buf_ff;
      if (m7) begin
         tx_body[7] = extra_en ? tx_par : 1'b1;
      end else begin
         tx_body[8] = extra_en ? (m9 ? channel_mode_reg[acs_pkg::ACS_MODE_TX9] : tx_par) : 1'b1;
      end
      nxt_tx_tick = serial_tick_clock ? tx_tick_ff + 4'h1 : tx_tick_ff;
      nxt_tx_buf = tx_buf_ff;
      nxt_tx_full = tx_full_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_left = tx_left_ff;
      nxt_txd = txd_ff;
      nxt_tx_irq = 1'b0;
      if (tx_bit) begin
         if (tx_left_ff != 4'h0) begin
            nxt_txd = tx_sh_ff[0];
            nxt_tx_sh = {1'b1, tx_sh_ff[11:1]};
            nxt_tx_left = tx_left_ff - 4'h1;
         end else if (tx_load) begin
            nxt_txd = 1'b0;
            nxt_tx_sh = tx_body;
            nxt_tx_left = (m7 ? acs_pkg::ACS_BITS_7 : acs_pkg::ACS_BITS_8) + {3'h0, extra_en};
            nxt_tx_full = 1'b0;
            nxt_tx_irq = 1'b1;
         end else begin
            nxt_txd = 1'b1;
         end
      end
      if (wr && paddr == acs_pkg::ACS_OFF_BUFFER) begin
         nxt_tx_buf = pwdata[7:0];
         nxt_tx_full = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_tick_ff <= 4'h0;
         tx_buf_ff <= 8'h00;
         tx_full_ff <= 1'b0;
         tx_sh_ff <= 12'hFFF;
         tx_left_ff <= 4'h0;
         txd_ff <= 1'b1;
         tx_irq_ff <= 1'b0;
      end else begin
         tx_tick_ff <= nxt_tx_tick;
         tx_buf_ff <= nxt_tx_buf;
         tx_full_ff <= nxt_tx_full;
         tx_sh_ff <= nxt_tx_sh;
         tx_left_ff <= nxt_tx_left;
         txd_ff <= nxt_txd;
         tx_irq_ff <= nxt_tx_irq;
      end
   end

   // ***************************************************
   // Receiver
   // ***************************************************
   assign eval = serial_tick_clock & (rx_tick_ff == acs_pkg::ACS_SAMPLE_LAST) & (rx_state_ff != acs_pkg::ACS_RX_IDLE);
   assign maj = (win_ff[1] & win_ff[0]) | (win_ff[1] & rx_s) | (win_ff[0] & rx_s);
   assign rx_done = eval & (rx_state_ff == acs_pkg::ACS_RX_STOP);
   assign rx_last = (m7 ? acs_pkg::ACS_RXBITS_7 : acs_pkg::ACS_RXBITS_8) + {3'h0, extra_en} - 4'h1;
   assign rx_data = m7 ? {pe_ff & rx_sh_ff[7], rx_sh_ff[6:0]} : rx_sh_ff[7:0];
   assign rx_par_bit = m7 ? rx_sh_ff[7] : rx_sh_ff[8];
   assign rx_parity_error_flag = pe_ff & ~m9 & (rx_par_bit != ((m7 ? ^rx_sh_ff[6:0] : ^rx_sh_ff[7:0]) ^ ~even_ff));
   assign suppress = channel_mode_reg[acs_pkg::ACS_MODE_WAKE] & m9 & ~rx_sh_ff[8];
   assign receive_irq = rx_irq_ff;

   always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_tick = serial_tick_clock ? rx_tick_ff + 4'h1 : rx_tick_ff;
      nxt_rx_idx = rx_idx_ff;
      nxt_win = win_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_buf = channel_buffer_reg;
      nxt_rx9 = received_ninth_bit;
      nxt_rx_full = rx_full_ff;
      nxt_rx_irq = 1'b0;
      nxt_overrun_flag = overrun_flag;
      nxt_parity_error_flag = parity_error_flag;
      nxt_framing_error_flag = framing_error_flag;
      if (rd && paddr == acs_pkg::ACS_OFF_CONTROL) begin
         nxt_overrun_flag = overrun_flag & ~prdata_ff[acs_pkg::ACS_CTRL_OVERRUN_FLAG];
         nxt_parity_error_flag = parity_error_flag & ~prdata_ff[acs_pkg::ACS_CTRL_PARITY_ERROR_FLAG];
         nxt_framing_error_flag = framing_error_flag & ~prdata_ff[acs_pkg::ACS_CTRL_FRAMING_ERROR_FLAG];
      end
      if (rd && paddr == acs_pkg::ACS_OFF_BUFFER && snap_full_ff) begin
         nxt_rx_full = 1'b0;
      end
      if (serial_tick_clock && (rx_tick_ff == acs_pkg::ACS_SAMPLE_FIRST || rx_tick_ff == acs_pkg::ACS_SAMPLE_MID)) begin
         nxt_win = {win_ff[0], rx_s};
      end
      case (rx_state_ff)
         acs_pkg::ACS_RX_IDLE: begin
            if (!rx_s && on && channel_mode_reg[acs_pkg::ACS_MODE_RXEN]) begin
               nxt_rx_state = acs_pkg::ACS_RX_START;
               nxt_rx_tick = 4'h0;
            end
         end
         acs_pkg::ACS_RX_START: begin
            if (eval) begin
               nxt_rx_state = maj ? acs_pkg::ACS_RX_IDLE : acs_pkg::ACS_RX_DATA;
               nxt_rx_idx = 4'h0;
            end
         end
         acs_pkg::ACS_RX_DATA: begin
            if (eval) begin
               nxt_rx_sh[rx_idx_ff] = maj;
               nxt_rx_idx = rx_idx_ff + 4'h1;
               if (rx_idx_ff == rx_last) begin
                  nxt_rx_state = acs_pkg::ACS_RX_STOP;
               end
            end
         end
         acs_pkg::ACS_RX_STOP: begin
            if (eval) begin
               nxt_rx_state = acs_pkg::ACS_RX_IDLE;
               if (!maj) begin
                  nxt_framing_error_flag = 1'b1;
               end
               if (!suppress) begin
                  if (rx_full_ff && nxt_rx_full) begin
                     nxt_overrun_flag = 1'b1;
                  end else begin
                     nxt_rx_buf = rx_data;
                     nxt_rx9 = m9 ? rx_sh_ff[8] : (~m7 & pe_ff & rx_sh_ff[8]);
                     nxt_rx_full = 1'b1;
                     nxt_rx_irq = 1'b1;
                     if (rx_parity_error_flag) begin
                        nxt_parity_error_flag = 1'b1;
                     end
                  end
               end
               nxt_rx_sh = 10'h000;
            end
         end
         default: nxt_rx_state = acs_pkg::ACS_RX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_state_ff <= acs_pkg::ACS_RX_IDLE;
         rx_tick_ff <= 4'h0;
         rx_idx_ff <= 4'h0;
         win_ff <= 2'h3;
         rx_sh_ff <= 10'h000;
         channel_buffer_reg <= 8'h00;
         received_ninth_bit <= 1'b0;
         rx_full_ff <= 1'b0;
         rx_irq_ff <= 1'b0;
         overrun_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         framing_error_flag <= 1'b0;
      end else begin
         rx_state_ff <= nxt_rx_state;
         rx_tick_ff <= nxt_rx_tick;
         rx_idx_ff <= nxt_rx_idx;
         win_ff <= nxt_win;
         rx_sh_ff <= nxt_rx_sh;
         channel_buffer_reg <= nxt_rx_buf;
         received_ninth_bit <= nxt_rx9;
         rx_full_ff <= nxt_rx_full;
         rx_irq_ff <= nxt_rx_irq;
         overrun_flag <= nxt_overrun_flag;
         parity_error_flag <= nxt_parity_error_flag;
         framing_error_flag <= nxt_framing_error_flag;
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_tx_start_bit: assert property (tx_load |=> (txd == 1'b0) && !tx_full_ff || $past(wr)) else $error("no start bit");
   a_tx_lsb_first: assert property (tx_load |=> tx_sh_ff[0] == $past(tx_buf_ff[0])) else $error("not lsb first");
   a_tx_nine_len: assert property (tx_load && m9 |=> tx_left_ff == 4'hA) else $error("bad 9-bit length");
   a_start_noise: assert property (rx_state_ff == acs_pkg::ACS_RX_START && eval && maj |=>
                                   rx_state_ff == acs_pkg::ACS_RX_IDLE) else $error("noise accepted");
   a_overrun_set: assert property (rx_done && !suppress && rx_full_ff && !(rd && paddr == acs_pkg::ACS_OFF_BUFFER)
                                   |=> overrun_flag && $stable(channel_buffer_reg)) else $error("overrun missed");
   a_frame_err: assert property (rx_done && !maj |=> framing_error_flag) else $error("framing error missed");
   a_err_clear: assert property (rd && paddr == acs_pkg::ACS_OFF_CONTROL && prdata_ff[acs_pkg::ACS_CTRL_OVERRUN_FLAG] && !eval
                                 |=> !overrun_flag) else $error("error flag not cleared");
   a_wake_gate: assert property (receive_irq && $past(channel_mode_reg[acs_pkg::ACS_MODE_WAKE] && m9)
                                 |-> received_ninth_bit) else $error("wake-up frame not gated");
   a_div_zero: assert property (baud_pulse && baud_control_reg[3:0] == 4'h0 |-> bdiv_ff == 4'hF)
      else $error("zero divider not 16");
   a_rx_irq_pulse: assert property (receive_irq |-> rx_full_ff ##1 !receive_irq) else $error("receive event wrong");

   c_rx_frame: cover property (rx_done && !suppress && !rx_full_ff);
   c_tx_load: cover property (tx_load ##[1:300] transmit_irq);
   c_overrun: cover property (rx_done && rx_full_ff);
   c_noise: cover property (rx_state_ff == acs_pkg::ACS_RX_START && eval && maj);
endmodule : acs_uart
`default_nettype wire

// File: acs_remote.sv
`default_nettype none
module acs_remote (
   // Clock and line
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***************************************************
   // Remote frame driver and capture
   // ***************************************************
   initial rxd = 1'b1;
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         rxd <= f[i];
         repeat (32) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (32) @(posedge clk);
   endtask : send
   task automatic glitch();
      rxd <= 1'b0;
      repeat (6) @(posedge clk);
      rxd <= 1'b1;
   endtask : glitch
   task automatic recv(input int n, input int b, output logic [10:0] f, output logic ok);
      int t;
      f = '0;
      t = 0;
      while (txd === 1'b1 && t < 4 * b) begin
         @(posedge clk);
         t++;
      end
      ok = (t < 4 * b);
      repeat (b / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         f[i] = txd;
         repeat (b) @(posedge clk);
      end
   endtask : recv
endmodule : acs_remote
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic prescaler_run_bit = 1'b0, timer_zero_match = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, rxd, txd, transmit_irq, receive_irq, err, ok;
   logic [10:0] fr;
   int n_errors = 0, tests_run = 0, cyc = 0, n_tx = 0, n_rx = 0;
   `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); end end
   always #5 clk = ~clk;
   always @(posedge clk) begin
      timer_zero_match <= ~timer_zero_match;
      if (transmit_irq === 1'b1) n_tx++;
      if (receive_irq === 1'b1) n_rx++;
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         summarize();
      end
   end
   acs_uart DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
      .txd(txd), .prescaler_run_bit(prescaler_run_bit), .timer_zero_match(timer_zero_match),
      .transmit_irq(transmit_irq), .receive_irq(receive_irq));
   acs_remote far (.clk(clk), .txd(txd), .rxd(rxd));
   // ***************************************************
   // Bus and checks
   // ***************************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_tx(input logic [7:0] md, input logic [7:0] d, input int n, input logic [10:0] ex, input int b);
      int k;
      k = n_tx;
      apb(1'b1, acs_pkg::ACS_OFF_MODE, md);
      apb(1'b1, acs_pkg::ACS_OFF_BUFFER, d);
      far.recv(n, b, fr, ok);
      `CHK("tx start", 1'b1, ok)
      `CHK("tx frame", ex, fr)
      repeat (b) @(posedge clk);
      `CHK("tx irq", k + 1, n_tx)
      $display("test tx mode %0h done", md);
   endtask : t_tx
   task automatic t_rx(input logic [10:0] f, input logic [7:0] eb, input logic [7:0] ec, input int di);
      int k;
      k = n_rx;
      far.send(f, 11);
      `CHK("rx irq", k + di, n_rx)
      apb(1'b0, acs_pkg::ACS_OFF_CONTROL, 8'h00);
      `CHK("control", ec, rd[7:0])
      if (di == 1) begin
         apb(1'b0, acs_pkg::ACS_OFF_BUFFER, 8'h00);
         `CHK("rx data", eb, rd[7:0])
      end
      $display("test rx %0h done", f);
   endtask : t_rx
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_regs();
      apb(1'b0, acs_pkg::ACS_OFF_MODE, 8'h00);
      `CHK("mode reset", 32'h0000_0000, rd)
      apb(1'b0, 8'h14, 8'h00);
      `CHK("unmapped", 1'b1, err)
      apb(1'b1, acs_pkg::ACS_OFF_BAUD, 8'h12);
      apb(1'b0, acs_pkg::ACS_OFF_BAUD, 8'h00);
      `CHK("baud", 8'h12, rd[7:0])
      apb(1'b1, acs_pkg::ACS_OFF_CONTROL, 8'h60);
      $display("test regs done");
   endtask : t_regs
   task automatic t_noise();
      int k;
      k = n_rx;
      apb(1'b1, acs_pkg::ACS_OFF_MODE, 8'h16);
      far.glitch();
      repeat (200) @(posedge clk);
      `CHK("noise", k, n_rx)
      $display("test noise done");
   endtask : t_noise
   task automatic t_overrun();
      far.send({1'b1, 1'b0, 8'h11, 1'b0}, 11);
      far.send({1'b1, 1'b0, 8'h22, 1'b0}, 11);
      apb(1'b0, acs_pkg::ACS_OFF_CONTROL, 8'h00);
      `CHK("overrun", 8'h70, rd[7:0])
      apb(1'b0, acs_pkg::ACS_OFF_STATUS, 8'h00);
      `CHK("status", 8'h03, rd[7:0])
      apb(1'b0, acs_pkg::ACS_OFF_BUFFER, 8'h00);
      `CHK("kept data", 8'h11, rd[7:0])
      $display("test overrun done");
   endtask : t_overrun
   task automatic t_clear();
      apb(1'b0, acs_pkg::ACS_OFF_CONTROL, 8'h00);
      `CHK("errors cleared", 8'hE0, rd[7:0])
      $display("test clear done");
   endtask : t_clear
   task automatic t_wake();
      apb(1'b1, acs_pkg::ACS_OFF_MODE, 8'h1F);
      t_rx({1'b1, 1'b0, 8'h55, 1'b0}, 8'h00, 8'h60, 0);
      t_rx({1'b1, 1'b1, 8'hAA, 1'b0}, 8'hAA, 8'hE0, 1);
      $display("test wake done");
   endtask : t_wake
   task automatic t_div_zero();
      apb(1'b1, acs_pkg::ACS_OFF_BAUD, 8'h00);
      apb(1'b1, acs_pkg::ACS_OFF_CONTROL, 8'h20);
      t_tx(8'h01, 8'h34, 10, {1'b1, 1'b0, 7'h34, 1'b0}, 1024);
      $display("test divider zero done");
   endtask : t_div_zero
   task automatic summarize();
      $display("tests %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_tx(8'h16, 8'hA4, 11, {1'b1, 1'b1, 8'hA4, 1'b0}, 32);
      t_tx(8'h15, 8'h34, 10, {1'b1, 1'b1, 7'h34, 1'b0}, 32);
      prescaler_run_bit <= 1'b1;
      t_tx(8'h83, 8'h5A, 11, {1'b1, 1'b1, 8'h5A, 1'b0}, 512);
      t_noise();
      t_rx({1'b1, 1'b0, 8'h3C, 1'b0}, 8'h3C, 8'h60, 1);
      t_rx({1'b0, 1'b1, 8'h3C, 1'b0}, 8'h3C, 8'hEC, 1);
      t_clear();
      t_overrun();
      t_wake();
      t_div_zero();
      summarize();
   end
endmodule : testbench
`default_nettype wire
